// [hdl/dbg_defs.svh]
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH
// write-only register offsets
`define DBG_OFS_BUS_GRANT_CONTROL 8'h17
`define DBG_OFS_SLOT4 8'h21
`define DBG_OFS_SLOT3 8'h22
`define DBG_OFS_SLOT2 8'h23
`define DBG_OFS_SLOT1 8'h24
`define DBG_OFS_FIRST 8'h25
// bus_grant_control fields
`define DBG_BIT_GRANT_ENABLE 7
`define DBG_BIT_GRANT_FORCE 6
`define DBG_BUS_CTL_RESET 8'h00
`define DBG_RESERVED_MASK 8'h3f
// core fetch slot count
`define DBG_SLOT_COUNT 5
`endif

// [hdl/dbg_device.sv]
`timescale 1ns/100ps
`include "dbg_defs.svh"
// Function
// - host writes grant control only while halted
// - enable zero ignores requests, grant only if forced
// - enable one grants after current operation
// - force one asserts the grant pin
// - force zero releases the grant pin
// - host writes zeros to reserved bits
// - first-slot write leaves break, runs one
// - fetch slot 0 first, then 1..4
// - host loads only the slots used
// - host never injects six-byte instructions
// - slots 4..0 ascend, slot 0 highest
module dbg_device
  import dbg_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  dbg_link_if.device_mp link,
  input wire logic ext_bus_request_pin_i,
  input wire logic fetch_req_i,
  input wire logic insn_done_i,
  output logic ext_bus_grant_pin_o,
  output logic exec_start_o,
  output logic in_break_o,
  output logic [7:0] fetch_byte_o,
  output logic fetch_valid_o
);
  typedef struct packed {
    dbg_state_type state;
    logic grant_enable;
    logic grant_force;
    logic [2:0] req_sync;
    logic req_seen;
    logic grant;
    logic [7:0] slot0;
    logic [7:0] slot1;
    logic [7:0] slot2;
    logic [7:0] slot3;
    logic [7:0] slot4;
    logic [2:0] fetch_idx;
    logic start;
    logic [7:0] fbyte;
    logic fvalid;
    logic busy;
    logic brk;
  } dbg_dev_state_type;

  dbg_dev_state_type cur_ff;
  dbg_dev_state_type nxt_ff;

  // slot selection by fetch index
  function automatic logic [7:0] pick_slot(input dbg_dev_state_type s, input logic [2:0] i);
    unique case (i)
      3'h0: pick_slot = s.slot0;
      3'h1: pick_slot = s.slot1;
      3'h2: pick_slot = s.slot2;
      3'h3: pick_slot = s.slot3;
      default: pick_slot = s.slot4;
    endcase
  endfunction

  // next-state logic
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.start = 1'b0;
    nxt_ff.fvalid = 1'b0;
    nxt_ff.req_sync = {cur_ff.req_sync[1:0], ext_bus_request_pin_i};
    if (cur_ff.req_sync[2] == cur_ff.req_sync[1]) begin
      nxt_ff.req_seen = cur_ff.req_sync[2];
    end
    if (link.wr_valid) begin
      unique case (link.wr_addr)
        `DBG_OFS_BUS_GRANT_CONTROL: begin
          nxt_ff.grant_enable = link.wr_data[`DBG_BIT_GRANT_ENABLE];
          nxt_ff.grant_force = link.wr_data[`DBG_BIT_GRANT_FORCE];
        end
        `DBG_OFS_SLOT4: nxt_ff.slot4 = link.wr_data;
        `DBG_OFS_SLOT3: nxt_ff.slot3 = link.wr_data;
        `DBG_OFS_SLOT2: nxt_ff.slot2 = link.wr_data;
        `DBG_OFS_SLOT1: nxt_ff.slot1 = link.wr_data;
        `DBG_OFS_FIRST: begin
          nxt_ff.slot0 = link.wr_data;
          if (cur_ff.state == DBG_BREAK) begin
            nxt_ff.state = DBG_EXEC;
            nxt_ff.fetch_idx = 3'h0;
            nxt_ff.start = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // single instruction fetch from slots
    if (cur_ff.state == DBG_EXEC) begin
      if (fetch_req_i && cur_ff.fetch_idx < 3'(`DBG_SLOT_COUNT)) begin
        nxt_ff.fbyte = pick_slot(cur_ff, cur_ff.fetch_idx);
        nxt_ff.fvalid = 1'b1;
        nxt_ff.fetch_idx = cur_ff.fetch_idx + 3'h1;
      end
      if (insn_done_i) begin
        nxt_ff.state = DBG_BREAK;
      end
    end
    nxt_ff.busy = (nxt_ff.state != DBG_BREAK);
    nxt_ff.brk = (nxt_ff.state == DBG_BREAK); // registered break flag
    // grant: forced, or enabled request once idle
    nxt_ff.grant = cur_ff.grant_force ||
      (cur_ff.grant_enable && cur_ff.req_seen && cur_ff.state == DBG_BREAK
       && !link.wr_valid);
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff <= '0;
      cur_ff.brk <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign ext_bus_grant_pin_o = cur_ff.grant;
  assign exec_start_o = cur_ff.start;
  assign in_break_o = cur_ff.brk;
  assign fetch_byte_o = cur_ff.fbyte;
  assign fetch_valid_o = cur_ff.fvalid;
  assign link.busy = cur_ff.busy;
endmodule

// [hdl/dbg_host.sv]
`timescale 1ns/100ps
`include "dbg_defs.svh"
// host end: turns user commands into register writes
module dbg_host
  import dbg_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  dbg_link_if.host_mp link,
  input wire logic halted_i,
  input wire logic bus_ctl_req_i,
  input wire logic grant_enable_i,
  input wire logic grant_force_i,
  input wire logic insn_req_i,
  input wire logic [2:0] insn_len_i,
  input wire logic [39:0] insn_bytes_i,
  output logic ready_o,
  output logic refused_o
);
  typedef struct packed {
    logic active;
    logic [2:0] left;
    logic [39:0] bytes;
    logic wv;
    logic [7:0] wa;
    logic [7:0] wd;
    logic ready;
    logic refused;
  } dbg_host_state_type;

  dbg_host_state_type cur_ff;
  dbg_host_state_type nxt_ff;

  // sequencing of writes
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.wv = 1'b0;
    nxt_ff.refused = 1'b0;
    if (cur_ff.active) begin
      // slot k sits at first offset minus k
      nxt_ff.wv = 1'b1;
      nxt_ff.wa = 8'(`DBG_OFS_FIRST - {5'h0, cur_ff.left} + 8'h1);
      nxt_ff.wd = cur_ff.bytes[8 * (cur_ff.left - 3'h1) +: 8];
      nxt_ff.left = cur_ff.left - 3'h1;
      nxt_ff.active = (cur_ff.left != 3'h1);
    end else if (!link.busy && halted_i && bus_ctl_req_i) begin
      nxt_ff.wv = 1'b1;
      nxt_ff.wa = `DBG_OFS_BUS_GRANT_CONTROL;
      nxt_ff.wd = {grant_enable_i, grant_force_i, 6'h00};
    end else if (insn_req_i) begin
      if (insn_len_i == 3'h0 || insn_len_i > 3'(`DBG_SLOT_COUNT) || !halted_i
          || link.busy) begin
        nxt_ff.refused = 1'b1;
      end else begin
        nxt_ff.active = 1'b1;
        nxt_ff.left = insn_len_i;
        nxt_ff.bytes = insn_bytes_i;
      end
    end
    nxt_ff.ready = !nxt_ff.active;
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign link.wr_valid = cur_ff.wv;
  assign link.wr_addr = cur_ff.wa;
  assign link.wr_data = cur_ff.wd;
  assign ready_o = cur_ff.ready;
  assign refused_o = cur_ff.refused;
endmodule

// [hdl/dbg_link_if.sv]
`timescale 1ns/100ps
// register write link between host and device
interface dbg_link_if;
  logic wr_valid;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic busy;
  modport device_mp (input wr_valid, input wr_addr, input wr_data, output busy);
  modport host_mp (output wr_valid, output wr_addr, output wr_data, input busy);
endinterface

// [hdl/dbg_pkg.sv]
package dbg_pkg;
  typedef enum logic [1:0] {
    DBG_BREAK,
    DBG_EXEC,
    DBG_REG_OP
  } dbg_state_type;
endpackage

// [tb/dbg_assertions.sv]
`timescale 1ns/100ps
// link, start and grant checks
module dbg_assertions (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic busy,
  input wire logic ext_bus_grant_pin_o,
  input wire logic in_break_o,
  input wire logic exec_start_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence go_s; wr_valid && wr_addr == 8'h25 && in_break_o; endsequence
  sequence ctl_s; wr_valid && wr_addr == 8'h17; endsequence
  a_first_starts: assert property (go_s |=> busy && exec_start_o && !in_break_o)
    else $error("no start");
  a_start_once: assert property (exec_start_o |=> !exec_start_o)
    else $error("long start");
  a_no_restart: assert property (busy && $past(busy) |-> !exec_start_o)
    else $error("restart");
  a_other_slot: assert property (wr_valid && wr_addr != 8'h25 |=> !exec_start_o)
    else $error("bad start");
  a_force_on: assert property ((ctl_s and wr_data[6]) |-> ##[1:2] ext_bus_grant_pin_o)
    else $error("no force");
  a_all_off: assert property ((ctl_s and wr_data[7:6] == 2'h0) |=> ##1 !ext_bus_grant_pin_o [*3])
    else $error("grant on");
  a_grant_brk: assert property ($rose(ext_bus_grant_pin_o) |-> $past(in_break_o))
    else $error("grant busy");
  a_done_brk: assert property ($fell(busy) |-> in_break_o)
    else $error("no break");
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic clock_i = 0, rst_n_i = 0, req = 0, fr = 0, dn = 0, bq = 0, en = 0, fo = 0, iq = 0;
  logic [2:0] len = 3'h1;
  logic [39:0] by = 40'h0;
  logic grant, brk, est, fv, rdy, rf;
  logic [7:0] fb;
  int fails = 0, comparisons = 0, cyc = 0, seed = 90212;
  byte unsigned q[$];
  dbg_link_if lk ();
  // free clock
  always #2.5 clock_i = ~clock_i;
  dbg_device i_dbg_device (.clock_i, .rst_n_i, .link(lk.device_mp),
    .ext_bus_request_pin_i(req), .fetch_req_i(fr), .insn_done_i(dn),
    .ext_bus_grant_pin_o(grant), .exec_start_o(est), .in_break_o(brk),
    .fetch_byte_o(fb), .fetch_valid_o(fv));
  dbg_host i_dbg_host (.clock_i, .rst_n_i, .link(lk.host_mp), .halted_i(brk),
    .bus_ctl_req_i(bq), .grant_enable_i(en), .grant_force_i(fo), .insn_req_i(iq),
    .insn_len_i(len), .insn_bytes_i(by), .ready_o(rdy), .refused_o(rf));
  dbg_assertions i_chk (.clock_i, .rst_n_i, .wr_valid(lk.wr_valid), .wr_addr(lk.wr_addr),
    .wr_data(lk.wr_data), .busy(lk.busy), .ext_bus_grant_pin_o(grant),
    .in_break_o(brk), .exec_start_o(est));
  task w(int n);
    repeat (n) @(negedge clock_i);
  endtask
  task chk(logic [7:0] g, logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one grant control write, then the pin after the sync delay
  task ctl(logic e, logic f, logic x);
    en = e;
    fo = f;
    bq = 1;
    w(1);
    bq = 0;
    w(8);
    chk({7'h0, grant}, {7'h0, x});
  endtask
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    w(16);
    rst_n_i = 1;
    w(2);
    chk({6'h0, grant, brk}, 8'h01);
    req = 1;
    ctl(0, 0, 0);
    ctl(1, 0, 1);
    ctl(0, 1, 1);
    ctl(0, 0, 0);
    req = 0;
    $display("grant test done");
    for (int l = 1; l < 6; l++) begin
      by = {8'($random(seed)), 32'($random(seed))};
      len = 3'(l);
      q = {};
      for (int k = 0; k < l; k++)
        q.push_back(by[8*k +: 8]);
      iq = 1;
      w(1);
      iq = 0;
      for (int k = 0; k < 9 && lk.busy !== 1; k++)
        w(1);
      chk({6'h0, lk.busy, brk}, 8'h02);
      while (q.size() > 0) begin
        fr = 1;
        w(1);
        fr = 0;
        for (int k = 0; k < 3 && fv !== 1; k++)
          w(1);
        chk(fb, q.pop_front());
      end
      dn = 1;
      w(1);
      dn = 0;
      w(2);
      chk({6'h0, lk.busy, brk}, 8'h01);
      $display("insn test %0d done", l);
    end
    // six-byte request must be refused, nothing streamed
    len = 3'h6;
    iq = 1;
    w(1);
    iq = 0;
    chk({6'h0, rf, rdy}, 8'h03);
    w(2);
    chk({6'h0, lk.busy, brk}, 8'h01);
    $display("refuse test done");
    close_out;
  end
endmodule
